// File: hw/spt_timer.sv
`timescale 1ns/100ps
// Summary of operation
// RULE1: one prescaler, timer or watchdog, never both
// RULE2: assign bit 0 gives timer, 1 watchdog
// RULE3: timer ratio is two to code plus one
// RULE4: watchdog assigned: timer counts 1:1
// RULE5: prescaler count hidden and not writable
// RULE6: count write clears prescaler when timer-assigned
// RULE7: watchdog clear clears prescaler and watchdog
// RULE8: overflow flag set on wrap to 00h
// RULE9: only software clears the overflow flag
// RULE10: interrupt needs enable and flag together
// RULE11: sleep freezes counter, no overflow
// RULE12: external edge sampled on Q2 and Q4
// RULE13: clock select: 0 instruction clock, 1 external
// RULE14: edge select: 1 falling, 0 rising
// RULE15: count write blocks two instruction cycles
// RULE16: sense select: 0 pin, 1 oscillator
// RULE17: 8-bit prescaler, tap carry advances timer
module spt_timer
  import spt_pkg::*;
#(
  parameter int PRESCALE_WIDTH = 8
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic ext_count_pin,
  input wire logic sense_oscillator,
  input wire logic sleep_req,
  input wire logic watchdog_clear_instruction,
  output logic watchdog_tick,
  output logic overflow_irq,
  output logic irq
);
  import spt_pkg::*;

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [7:0] prescale_config;
  logic [7:0] cap_sense_control;
  logic [7:0] interrupt_control;
  logic [7:0] count_value;
  logic [SPT_EV_NUM-1:0] status;
  logic [SPT_EV_NUM-1:0] mask;
  logic sleep_sw;

  logic [7:0] a_addr;
  logic a_write;
  logic a_valid;
  logic wr_cfg, wr_sns, wr_irq, wr_cnt, wr_sts, wr_msk, wr_ctl;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // ----------------------------------------
  // ahb-lite slave: zero wait, always okay
  // ----------------------------------------
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // address phase capture
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      a_addr <= 8'h00;
      a_write <= 1'b0;
      a_valid <= 1'b0;
    end
    else if (hready)
    begin
      a_addr <= haddr[7:0];
      a_write <= hwrite;
      a_valid <= hsel && htrans[1];
    end
  end

  // data phase write strobes
  always_comb
  begin
    wr_cfg = a_valid && a_write && hit(a_addr, SPT_OFF_CONFIG);
    wr_sns = a_valid && a_write && hit(a_addr, SPT_OFF_SENSE);
    wr_irq = a_valid && a_write && hit(a_addr, SPT_OFF_IRQCTL);
    wr_cnt = a_valid && a_write && hit(a_addr, SPT_OFF_COUNT);
    wr_sts = a_valid && a_write && hit(a_addr, SPT_OFF_STATUS);
    wr_msk = a_valid && a_write && hit(a_addr, SPT_OFF_MASK);
    wr_ctl = a_valid && a_write && hit(a_addr, SPT_OFF_CTRL);
  end

  // read mux; prescaler count has no address, unmapped reads zero
  always_comb
  begin
    hrdata = 32'h0000_0000;
    if (a_valid && !a_write)
    begin
      case (a_addr)
        SPT_OFF_CONFIG: hrdata = {24'h00_0000, prescale_config};
        SPT_OFF_SENSE: hrdata = {24'h00_0000, cap_sense_control};
        SPT_OFF_IRQCTL: hrdata = {24'h00_0000, interrupt_control};
        SPT_OFF_COUNT: hrdata = {24'h00_0000, count_value};
        SPT_OFF_STATUS: hrdata = {30'h0000_0000, status};
        SPT_OFF_MASK: hrdata = {30'h0000_0000, mask};
        SPT_OFF_CTRL: hrdata = {31'h0000_0000, sleep_sw};
        default: hrdata = 32'h0000_0000;
      endcase
    end
  end // RULE5

  // plain configuration registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prescale_config <= SPT_CFG_RESET;
      cap_sense_control <= SPT_SNS_RESET;
      mask <= '0;
      sleep_sw <= 1'b0;
    end
    else
    begin
      if (wr_cfg)
        prescale_config <= hwdata[7:0];
      if (wr_sns)
        cap_sense_control <= {7'h00, hwdata[SPT_SNS_EXT_SEL]};
      if (wr_msk)
        mask <= hwdata[SPT_EV_NUM-1:0];
      if (wr_ctl)
        sleep_sw <= hwdata[SPT_CTL_SLEEP];
    end
  end

  wire logic to_timer = !prescale_config[SPT_CFG_ASSIGN]; // RULE1 RULE2
  wire logic [2:0] rate = prescale_config[SPT_CFG_RATE_LSB +: 3];
  wire logic sleeping = sleep_req || sleep_sw;

  // ----------------------------------------
  // instruction clock phases
  // ----------------------------------------
  spt_phase_t phase;
  logic cycle_end;

  // four phases make one instruction cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      phase <= SPT_Q1;
    else
    begin
      case (phase)
        SPT_Q1: phase <= SPT_Q2;
        SPT_Q2: phase <= SPT_Q3;
        SPT_Q3: phase <= SPT_Q4;
        SPT_Q4: phase <= SPT_Q1;
        default: phase <= SPT_Q1;
      endcase
    end
  end
  assign cycle_end = (phase == SPT_Q4);

  // ----------------------------------------
  // external source: sync and edge detect
  // ----------------------------------------
  logic [1:0] pin_sync;
  logic [1:0] osc_sync;
  logic ext_prev;
  logic ext_level;
  logic ext_edge;

  // pins cross into clk through two flops each
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_sync <= 2'b00;
      osc_sync <= 2'b00;
      // synced pins read low here; match the reset edge polarity so no false edge follows reset
      ext_prev <= SPT_CFG_RESET[SPT_CFG_EDGE_SEL];
    end
    else
    begin
      pin_sync <= {pin_sync[0], ext_count_pin};
      osc_sync <= {osc_sync[0], sense_oscillator};
      ext_prev <= ext_level;
    end
  end

  // source mux, polarity flip turns falling into rising
  assign ext_level = (cap_sense_control[SPT_SNS_EXT_SEL] ? osc_sync[1] : pin_sync[1]) // RULE16
                     ^ prescale_config[SPT_CFG_EDGE_SEL]; // RULE14
  assign ext_edge = ext_level && !ext_prev;

  // raw source event; clock select picks instruction cycle or edge
  wire logic src_event = prescale_config[SPT_CFG_CLK_SEL] ? ext_edge : cycle_end; // RULE13

  // ----------------------------------------
  // shared prescaler
  // ----------------------------------------
  logic [PRESCALE_WIDTH-1:0] prescale;
  logic [PRESCALE_WIDTH-1:0] next_prescale;
  logic tap_carry;
  logic wdt_tap;

  assign next_prescale = prescale + 1'b1;

  // prescaler advances on each source event while not sleeping;
  // cleared by a count write (timer) or watchdog clear (watchdog)
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      prescale <= '0;
    else if ((wr_cnt && to_timer) // RULE6
             || (!to_timer && (watchdog_clear_instruction
             || (wr_ctl && hwdata[SPT_CTL_WDT_CLEAR])))) // RULE7
      prescale <= '0;
    else if (src_event && !sleeping)
      prescale <= next_prescale;
  end

  logic [PRESCALE_WIDTH-1:0] rate_mask;

  // low rate+1 prescaler bits; all ones means the next event carries out of the tap
  always_comb
  begin
    for (int i = 0; i < PRESCALE_WIDTH; i++)
      rate_mask[i] = (i <= int'(rate));
  end

  // carry out of selected tap: bit rate toggles from 1 to 0
  assign tap_carry = src_event && !sleeping && ((prescale & rate_mask) == rate_mask); // RULE3 RULE17
  // watchdog sees half the timer ratio, 1:1 at code 000
  assign wdt_tap = src_event && !sleeping
                   && ((prescale & (rate_mask >> 1)) == (rate_mask >> 1)); // RULE4
  assign watchdog_tick = !to_timer && wdt_tap; // RULE1

  // ----------------------------------------
  // q2/q4 sampler and write hold
  // ----------------------------------------
  logic pend;
  logic inc;
  logic [3:0] hold;

  // prescaler output latched, then taken on q2 or q4 only
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pend <= 1'b0;
    else if (wr_cnt)
      pend <= 1'b0;
    else if (phase == SPT_Q2 || phase == SPT_Q4) // RULE12
      pend <= 1'b0;
    else if ((to_timer ? tap_carry : (src_event && !sleeping)))
      pend <= 1'b1;
  end

  wire logic raw_inc = to_timer ? tap_carry : (src_event && !sleeping); // RULE4
  assign inc = (phase == SPT_Q2 || phase == SPT_Q4) && (pend || raw_inc) && (hold == 4'h0) && !sleeping; // RULE11 RULE12

  // two instruction cycles of inhibit after a count write;
  // counted in clocks so a write late in a cycle does not shorten it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold <= 4'h0;
    else if (wr_cnt)
      hold <= 4'(SPT_WRITE_HOLD_CYC * SPT_PHASES); // RULE15
    else if (hold != 4'h0)
      hold <= hold - 4'h1;
  end

  // ----------------------------------------
  // counter and overflow
  // ----------------------------------------
  wire logic wrap = inc && (count_value == 8'hff);

  // count register; software write wins over increment
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      count_value <= 8'h00;
    else if (wr_cnt)
      count_value <= hwdata[7:0];
    else if (inc)
      count_value <= count_value + 8'h01;
  end

  // interrupt control: flag set wins over software clear
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      interrupt_control <= SPT_IRQ_RESET;
    else
    begin
      if (wr_irq)
        interrupt_control <= {2'b00, hwdata[SPT_IRQ_ENABLE], 2'b00, hwdata[SPT_IRQ_FLAG] | wrap, 2'b00}; // RULE9
      else if (wrap)
        interrupt_control[SPT_IRQ_FLAG] <= 1'b1; // RULE8
    end
  end

  assign overflow_irq = interrupt_control[SPT_IRQ_ENABLE] && interrupt_control[SPT_IRQ_FLAG]; // RULE10

  // ----------------------------------------
  // sticky status, write one to clear
  // ----------------------------------------
  wire logic [SPT_EV_NUM-1:0] ev = {watchdog_tick && (prescale == '0), wrap};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      status <= '0;
    else
      status <= ev | (status & ~(wr_sts ? hwdata[SPT_EV_NUM-1:0] : '0));
  end

  assign irq = |(status & mask);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  chk_flag_on_wrap: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    wrap |=> interrupt_control[SPT_IRQ_FLAG])
    else $error("overflow flag not set after wrap");
  chk_flag_sticky: assert property (@(posedge clk) disable iff (!rst_n) // RULE9
    $fell(interrupt_control[SPT_IRQ_FLAG]) |-> $past(wr_irq))
    else $error("overflow flag cleared without software");
  chk_irq_gate: assert property (@(posedge clk) disable iff (!rst_n) // RULE10
    $rose(overflow_irq) |-> $past(wrap || wr_irq))
    else $error("overflow request rose without wrap or software write");
  chk_sleep_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE11
    (sleeping && !wr_cnt) |=> $stable(count_value))
    else $error("counter moved during sleep");
  chk_write_hold: assert property (@(posedge clk) disable iff (!rst_n) // RULE15
    wr_cnt |=> !inc [*8])
    else $error("count advanced right after write");
  chk_phase_sample: assert property (@(posedge clk) disable iff (!rst_n) // RULE12
    inc |-> (phase == SPT_Q2 || phase == SPT_Q4))
    else $error("increment outside q2 or q4");
  chk_presc_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE6
    (wr_cnt && to_timer) |=> prescale == '0)
    else $error("prescaler not cleared by count write");
  chk_wdt_clear: assert property (@(posedge clk) disable iff (!rst_n) // RULE7
    (!to_timer && watchdog_clear_instruction) |=> prescale == '0)
    else $error("prescaler not cleared by watchdog clear");
  chk_one_owner: assert property (@(posedge clk) disable iff (!rst_n) // RULE1
    to_timer |-> !watchdog_tick)
    else $error("watchdog ticks while prescaler on timer");
  chk_wrap_zero: assert property (@(posedge clk) disable iff (!rst_n) // RULE8
    (wrap && !wr_cnt) |=> count_value == 8'h00)
    else $error("wrap did not land on zero");
endmodule

// File: hw/spt_pkg.sv
package spt_pkg;
  // register byte offsets
  localparam logic [7:0] SPT_OFF_CONFIG = 8'h00;
  localparam logic [7:0] SPT_OFF_SENSE = 8'h04;
  localparam logic [7:0] SPT_OFF_IRQCTL = 8'h08;
  localparam logic [7:0] SPT_OFF_COUNT = 8'h0c;
  localparam logic [7:0] SPT_OFF_STATUS = 8'h10;
  localparam logic [7:0] SPT_OFF_MASK = 8'h14;
  localparam logic [7:0] SPT_OFF_CTRL = 8'h18;
  // prescale_config fields
  localparam int SPT_CFG_CLK_SEL = 5;
  localparam int SPT_CFG_EDGE_SEL = 4;
  localparam int SPT_CFG_ASSIGN = 3;
  localparam int SPT_CFG_RATE_LSB = 0;
  localparam logic [7:0] SPT_CFG_RESET = 8'hff;
  // cap_sense_control fields
  localparam int SPT_SNS_EXT_SEL = 0;
  localparam logic [7:0] SPT_SNS_RESET = 8'h00;
  // interrupt_control fields
  localparam int SPT_IRQ_ENABLE = 5;
  localparam int SPT_IRQ_FLAG = 2;
  localparam logic [7:0] SPT_IRQ_RESET = 8'h00;
  // event status bits
  localparam int SPT_EV_OVF = 0;
  localparam int SPT_EV_WRAP_WDT = 1;
  localparam int SPT_EV_NUM = 2;
  // control register bits
  localparam int SPT_CTL_SLEEP = 0;
  localparam int SPT_CTL_WDT_CLEAR = 1;
  // timing
  localparam int SPT_PHASES = 4;
  localparam int SPT_WRITE_HOLD_CYC = 2;
  typedef enum logic [1:0] {SPT_Q1, SPT_Q2, SPT_Q3, SPT_Q4} spt_phase_t;
endpackage

// File: test/spt_source_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// far-side count source: pin or oscillator
// ----------------------------------------
module spt_source_model (
  input wire logic clk,
  input wire logic start,
  input wire logic use_osc,
  input wire logic [7:0] n_edges,
  input wire logic [3:0] half,
  output logic ext_count_pin,
  output logic sense_oscillator,
  output logic busy
);
  logic pin_lvl = 1'b0;
  logic osc_lvl = 1'b0;
  logic noise = 1'b0;
  logic [7:0] left = 8'h00;
  logic [3:0] cnt = 4'h0;
  initial busy = 1'b0;
  // burst of transitions; each level held half+1 clocks so phase sampling sees it
  always @(posedge clk)
  begin
    noise <= ~noise;
    if (start && !busy)
    begin
      busy <= 1'b1;
      left <= n_edges;
      cnt <= half;
    end
    else if (busy && cnt == 4'h0)
    begin
      pin_lvl <= use_osc ? pin_lvl : ~pin_lvl;
      osc_lvl <= use_osc ? ~osc_lvl : osc_lvl;
      left <= left - 8'h01;
      cnt <= half;
      busy <= (left != 8'h01);
    end
    else if (busy)
      cnt <= cnt - 4'h1;
  end
  // idle source wiggles every cycle, so a wrong source select shows as extra counts
  assign ext_count_pin = use_osc ? noise : pin_lvl;
  assign sense_oscillator = use_osc ? osc_lvl : noise;
endmodule

// File: test/spt_timer_test.sv
`timescale 1ns/100ps
// ----------------------------------------
// bench for the shared prescaler timer
// ----------------------------------------
module spt_timer_test;
  import spt_pkg::*;
  typedef struct {string name; logic [31:0] lo; logic [31:0] hi;} spt_note_t;
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, pin, osc, sleep_req, wd_clr, wd_tick, ovf_irq, irq;
  logic start, use_osc, busy;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] half;
  logic [7:0] n_edges;
  logic [31:0] haddr, hwdata, hrdata, res_val, scratch;
  logic [7:0] cfg_tab [4] = '{8'h28, 8'h38, 8'h28, 8'h20};
  spt_note_t notes[$];
  spt_note_t cur;
  event res_ev;
  int n_fail = 0;
  int total_checks = 0;
  int seed = 97;
  int n_tick = 0;
  int lvl [2] = '{0, 0};
  int n, e, s;
  spt_timer DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .ext_count_pin(pin), .sense_oscillator(osc), .sleep_req(sleep_req),
    .watchdog_clear_instruction(wd_clr), .watchdog_tick(wd_tick), .overflow_irq(ovf_irq), .irq(irq));
  spt_source_model src (.clk(clk), .start(start), .use_osc(use_osc), .n_edges(n_edges), .half(half),
    .ext_count_pin(pin), .sense_oscillator(osc), .busy(busy));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // prescaled events handed to the watchdog
  always @(posedge clk)
    if (wd_tick === 1'b1)
      n_tick <= n_tick + 1;
  // checker: oldest note against each result that appears
  initial
    forever
    begin
      @(res_ev);
      cur = notes.pop_front();
      total_checks++;
      if (res_val !== cur.lo && (res_val < cur.lo || res_val > cur.hi || ^res_val === 1'bx))
      begin
        n_fail++;
        $display("FAIL %s expected %h..%h seen %h", cur.name, cur.lo, cur.hi, res_val);
      end
    end
  task automatic note(input string nm, input logic [31:0] lo, input logic [31:0] hi, input logic [31:0] v);
    notes.push_back('{nm, lo, hi});
    res_val = v;
    -> res_ev;
    #1;
  endtask
  // single word transfer; hready sampled at each rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    ahb(1'b1, a, {24'h0, d}, scratch);
    #1;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] lo, input logic [31:0] hi);
    ahb(1'b0, a, 32'h0, scratch);
    note(nm, lo, hi, scratch);
  endtask
  task automatic instr(input int k);
    repeat (k * SPT_PHASES) @(posedge clk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // watchdog: the whole run needs well under 40000 cycles
  initial
  begin
    #400000;
    n_fail++;
    conclude();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    {rst_n, hsel, hwrite, sleep_req, wd_clr, start, use_osc} = 7'h00;
    {htrans, haddr, hwdata, half, n_edges} = '0;
    hsize = 3'b010;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd("config reset", SPT_OFF_CONFIG, 32'hff, 32'hff);
    rd("sense reset", SPT_OFF_SENSE, 32'h0, 32'h0);
    rd("irqctl reset", SPT_OFF_IRQCTL, 32'h0, 32'h0);
    rd("unmapped", 8'h1c, 32'h0, 32'h0);
    note("hresp okay", 32'h0, 32'h0, {31'h0, hresp});
    $display("test reset values done");
    n_tick = 0;
    for (int c = 0; c < 8; c++)
    begin
      wr(SPT_OFF_CONFIG, 8'(c));
      wr(SPT_OFF_COUNT, 8'h00);
      instr(2 + 9 * (1 << c));
      rd("count at rate", SPT_OFF_COUNT, 32'h4, 32'h5);
    end
    note("ticks timer assigned", 32'h0, 32'h0, 32'(n_tick));
    $display("test rate codes done");
    wr(SPT_OFF_CONFIG, 8'h08);
    wr(SPT_OFF_COUNT, 8'h10);
    rd("count after write", SPT_OFF_COUNT, 32'h10, 32'h10);
    instr(8);
    rd("count one to one", SPT_OFF_COUNT, 32'h16, 32'h18);
    wd_clr <= 1'b1;
    @(posedge clk);
    wd_clr <= 1'b0;
    note("ticks watchdog assigned", 32'h1, 32'hffff, 32'(n_tick));
    $display("test one to one done");
    wr(SPT_OFF_COUNT, 8'hfc);
    instr(12);
    sleep_req <= 1'b1;
    rd("flag after wrap", SPT_OFF_IRQCTL, 32'h04, 32'h04);
    note("overflow_irq disabled", 32'h0, 32'h0, {31'h0, ovf_irq});
    note("irq masked", 32'h0, 32'h0, {31'h0, irq});
    wr(SPT_OFF_MASK, 8'h01);
    note("irq unmasked", 32'h1, 32'h1, {31'h0, irq});
    wr(SPT_OFF_IRQCTL, 8'h24);
    note("overflow_irq enabled", 32'h1, 32'h1, {31'h0, ovf_irq});
    rd("count asleep", SPT_OFF_COUNT, 32'h05, 32'h08);
    instr(300);
    rd("count still asleep", SPT_OFF_COUNT, 32'h05, 32'h08);
    rd("flag kept", SPT_OFF_IRQCTL, 32'h24, 32'h24);
    wr(SPT_OFF_IRQCTL, 8'h20);
    rd("flag cleared", SPT_OFF_IRQCTL, 32'h20, 32'h20);
    note("overflow_irq cleared", 32'h0, 32'h0, {31'h0, ovf_irq});
    wr(SPT_OFF_STATUS, 8'h03);
    note("irq cleared", 32'h0, 32'h0, {31'h0, irq});
    wr(SPT_OFF_CTRL, 8'h01);
    sleep_req <= 1'b0;
    rd("soft sleep bit", SPT_OFF_CTRL, 32'h1, 32'h1);
    instr(20);
    rd("count soft sleep", SPT_OFF_COUNT, 32'h05, 32'h08);
    wr(SPT_OFF_CTRL, 8'h02);
    rd("soft sleep off", SPT_OFF_CTRL, 32'h0, 32'h0);
    $display("test overflow done");
    for (int i = 0; i < 4; i++)
    begin
      s = (i == 2);
      use_osc <= s[0];
      wr(SPT_OFF_SENSE, 8'(s));
      wr(SPT_OFF_CONFIG, cfg_tab[i]);
      wr(SPT_OFF_COUNT, 8'h00);
      instr(3);
      n = 2 + ($random(seed) & 15);
      half <= 4'(8 + ($random(seed) & 7));
      n_edges <= 8'(n);
      e = 0;
      for (int k = 0; k < n; k++)
      begin
        lvl[s] = 1 - lvl[s];
        e += (lvl[s] == (cfg_tab[i][4] ? 0 : 1));
      end
      start <= 1'b1;
      repeat (2) @(posedge clk);
      start <= 1'b0;
      while (busy === 1'b1) @(posedge clk);
      instr(4);
      rd("counted edges", SPT_OFF_COUNT, 32'(e / (i == 3 ? 2 : 1)), 32'(e / (i == 3 ? 2 : 1)));
    end
    $display("test counter mode done");
    conclude();
  end
endmodule
